// *** src/counter_array_watchdog.sv ***
`include "counter_array_regs.svh"
module counter_array_watchdog
  import counter_array_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // special-function register access
  input  wire sfr_req_type sfr_req_i,
  output logic [7:0]       sfr_rdata_o,
  // timebase sources and core state
  input  wire logic        idle_i,
  input  wire logic        timer0_ovf_i,
  input  wire logic        eci_pin_i,
  input  wire logic        ext_div8_tick_i,
  input  wire logic        rtc_div8_tick_i,
  // other compare modules
  input  wire logic [4:0]  module_match_i,
  input  wire logic [4:0]  module_irq_en_i,
  // results
  output logic             wd_reset_o,
  output logic             irq_o,
  output logic             pwm5_o
);

  logic        cf_reg;
  logic        cr_reg;
  logic [5:0]  ccf_reg;
  logic        idle_suspend_bit_reg;
  logic        wde_reg;
  logic        wd_lock_bit_reg;
  logic [2:0]  cps_reg;
  logic        ecf_reg;
  logic [15:0] cnt_reg;
  logic [7:0]  cpl5_reg;
  logic [7:0]  cph5_reg;
  logic [7:0]  cpm5_reg;
  logic [3:0]  div_reg;
  logic [2:0]  eci_sync_reg;
  logic        wd_reset_reg;
  logic        irq_reg;
  logic        pwm_reg;
  logic [7:0]  rdata_reg;

  // register decode
  wire         wr_cs   = sfr_req_i.wr && sfr_req_i.addr == `ADDR_CONTROL_STATUS;
  wire         wr_md   = sfr_req_i.wr && sfr_req_i.addr == `ADDR_MODE;
  wire         wr_cnl  = sfr_req_i.wr && sfr_req_i.addr == `ADDR_COUNT_LOW;
  wire         wr_cnh  = sfr_req_i.wr && sfr_req_i.addr == `ADDR_COUNT_HIGH;
  wire         wr_off  = sfr_req_i.wr && sfr_req_i.addr == `ADDR_WD_OFFSET;
  wire         wr_svc  = sfr_req_i.wr && sfr_req_i.addr == `ADDR_WD_SERVICE;
  wire         wr_m5   = sfr_req_i.wr && sfr_req_i.addr == `ADDR_MODULE5_MODE;
  wire [7:0]   wdata   = sfr_req_i.data;

  wire         wd_en   = wde_reg || wd_lock_bit_reg;
  wire         run     = cr_reg || wd_en;

  // timebase selection
  wire         div12_tick = div_reg == `DIV12_LAST;
  wire         div4_tick  = div_reg[1:0] == `DIV4_LAST;
  wire         eci_fall   = eci_sync_reg[2] && !eci_sync_reg[1];
  logic        src_tick;
  always_comb
  begin
    case (cps_reg)
      `CPS_DIV12:  src_tick = div12_tick;
      `CPS_DIV4:   src_tick = div4_tick;
      `CPS_TIMER0: src_tick = timer0_ovf_i;
      `CPS_ECI:    src_tick = eci_fall;
      `CPS_SYSTEM_CLOCK: src_tick = 1'b1;
      `CPS_EXT8:   src_tick = ext_div8_tick_i;
      `CPS_RTC8:   src_tick = rtc_div8_tick_i;
      default:     src_tick = 1'b0;
    endcase
  end

  wire         suspend  = idle_suspend_bit_reg && idle_i;
  wire         tick     = run && src_tick && !suspend;
  wire [15:0]  cnt_inc  = cnt_reg + 16'h0001;
  wire         low_ovf  = tick && cnt_reg[7:0] == 8'hff;
  wire         wrap16   = tick && cnt_reg == 16'hffff;
  wire         svc_hit  = cph5_reg == cnt_reg[15:8];
  wire         timeout  = wd_en && low_ovf && svc_hit;
  wire         force_rs = wd_en && wr_cs && wdata[`CS_MATCH5_BIT];
  wire [7:0]   svc_load = cnt_reg[15:8] + cpl5_reg;

  // module 5 as compare module when the watchdog is off
  wire         m5_ecom  = cpm5_reg[`M5_ECOM_BIT];
  wire         m5_hit   = !wd_en && tick && cnt_inc == {cph5_reg, cpl5_reg};
  wire         m5_set   = m5_hit && m5_ecom && cpm5_reg[`M5_MAT_BIT];
  wire         pwm16    = !wd_en && cpm5_reg[`M5_PWM16_BIT] && cpm5_reg[`M5_PWM_BIT];
  wire [5:0]   ccf_set  = {m5_set, module_match_i};
  wire         irq_next = (cf_reg && ecf_reg)
                        || |(ccf_reg[4:0] & module_irq_en_i)
                        || (ccf_reg[5] && cpm5_reg[`M5_ECCF_BIT]);

  logic [7:0]  rdata_next;
  always_comb
  begin
    case (sfr_req_i.addr)
      `ADDR_CONTROL_STATUS: rdata_next = {cf_reg, cr_reg, ccf_reg};
      `ADDR_MODE:           rdata_next = {idle_suspend_bit_reg, wde_reg, wd_lock_bit_reg, 1'b0, cps_reg, ecf_reg};
      `ADDR_COUNT_LOW:      rdata_next = cnt_reg[7:0];
      `ADDR_COUNT_HIGH:     rdata_next = cnt_reg[15:8];
      `ADDR_WD_OFFSET:      rdata_next = cpl5_reg;
      `ADDR_WD_SERVICE:     rdata_next = cph5_reg;
      `ADDR_MODULE5_MODE:   rdata_next = cpm5_reg;
      default:              rdata_next = 8'h00;
    endcase
  end

  // prescaler and pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_reg      <= 4'h0;
      eci_sync_reg <= 3'h7;
    end
    else
    begin
      div_reg      <= div12_tick ? 4'h0 : div_reg + 4'h1;
      eci_sync_reg <= {eci_sync_reg[1:0], eci_pin_i};
    end
  end

  // control and status flags
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cf_reg  <= 1'b0;
      cr_reg  <= 1'b0;
      ccf_reg <= 6'h00;
    end
    else
    begin
      if (wr_cs)
      begin
        cf_reg  <= wrap16 || wdata[`CS_OVERFLOW_BIT];
        cr_reg  <= wdata[`CS_RUN_BIT];
        ccf_reg <= ccf_set | wdata[5:0];
      end
      else
      begin
        cf_reg  <= cf_reg || wrap16;
        ccf_reg <= ccf_reg | ccf_set;
      end
    end
  end

  // mode register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      idle_suspend_bit_reg  <= 1'b0;
      wde_reg   <= 1'b1;
      wd_lock_bit_reg <= 1'b0;
      cps_reg   <= `CPS_DIV12;
      ecf_reg   <= 1'b0;
    end
    else if (wr_md)
    begin
      wd_lock_bit_reg <= wd_lock_bit_reg || wdata[`MD_LOCK_BIT];
      wde_reg   <= wdata[`MD_ENABLE_BIT] || (wd_lock_bit_reg && wde_reg);
      if (!wde_reg)
        ecf_reg <= wdata[`MD_ECF_BIT];
      if (!wd_en)
      begin
        idle_suspend_bit_reg <= wdata[`MD_IDLE_BIT];
        cps_reg  <= wdata[`MD_CPS_LSB +: 3];
      end
    end
  end

  // counter
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      cnt_reg <= `RESET_COUNT;
    else if (wr_cnl && !wd_en)
      cnt_reg <= {cnt_reg[15:8], wdata};
    else if (wr_cnh && !wd_en)
      cnt_reg <= {wdata, cnt_reg[7:0]};
    else if (tick)
      cnt_reg <= cnt_inc;
  end

  // module 5 registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cpl5_reg <= `RESET_BYTE;
      cph5_reg <= `RESET_BYTE;
      cpm5_reg <= `RESET_BYTE;
    end
    else
    begin
      if (wr_off)
        cpl5_reg <= wdata;
      if (wr_svc)
        cph5_reg <= wd_en ? svc_load : wdata;
      if (wr_m5 && !wd_en)
        cpm5_reg <= wdata;
      else if (wr_off && !wd_en)
        cpm5_reg[`M5_ECOM_BIT] <= 1'b0;
      else if (wr_svc && !wd_en)
        cpm5_reg[`M5_ECOM_BIT] <= 1'b1;
    end
  end

  // outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wd_reset_reg <= 1'b0;
      irq_reg      <= 1'b0;
      pwm_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
    end
    else
    begin
      wd_reset_reg <= timeout || force_rs;
      irq_reg      <= irq_next;
      if (!pwm16 || !m5_ecom)
        pwm_reg <= 1'b0;
      else if (m5_hit)
        pwm_reg <= 1'b1;
      else if (wrap16)
        pwm_reg <= 1'b0;
      if (sfr_req_i.rd)
        rdata_reg <= rdata_next;
    end
  end

  assign wd_reset_o  = wd_reset_reg;
  assign irq_o       = irq_reg;
  assign pwm5_o      = pwm_reg;
  assign sfr_rdata_o = rdata_reg;

  property p_reset_enabled;
    @(posedge clk_i) $fell(reset_i) |-> wd_en && !cr_reg;
  endproperty
  a_reset_enabled: assert property (p_reset_enabled)
    else $error("watchdog not enabled after reset");

  property p_timeout;
    @(posedge clk_i) disable iff (reset_i)
      timeout |=> wd_reset_o ##1 (!wd_reset_o || $past(timeout || force_rs));
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("missing watchdog timeout pulse");

  property p_force;
    @(posedge clk_i) disable iff (reset_i)
      wd_en && wr_cs && wdata[`CS_MATCH5_BIT] |=> wd_reset_o;
  endproperty
  a_force: assert property (p_force)
    else $error("forced reset not raised");

  property p_count_locked;
    @(posedge clk_i) disable iff (reset_i)
      wd_en && (wr_cnl || wr_cnh) && !tick |=> $stable(cnt_reg);
  endproperty
  a_count_locked: assert property (p_count_locked)
    else $error("counter written while watchdog enabled");

  property p_mode_frozen;
    @(posedge clk_i) disable iff (reset_i) wd_en |=> $stable(cps_reg) && $stable(idle_suspend_bit_reg);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("clock select changed while watchdog enabled");

  property p_lock;
    @(posedge clk_i) disable iff (reset_i) wd_lock_bit_reg |=> wd_lock_bit_reg && wd_en;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked watchdog was disabled");

  property p_service;
    @(posedge clk_i) disable iff (reset_i)
      wd_en && wr_svc |=> cph5_reg == 8'($past(cnt_reg[15:8]) + $past(cpl5_reg));
  endproperty
  a_service: assert property (p_service)
    else $error("service did not load high byte plus offset");

  property p_forced_run;
    @(posedge clk_i) disable iff (reset_i)
      wd_en && !cr_reg && src_tick && !suspend && !wr_cnl && !wr_cnh
      |=> cnt_reg == 16'($past(cnt_reg) + 16'h0001);
  endproperty
  a_forced_run: assert property (p_forced_run)
    else $error("counter stalled while watchdog enabled");

  property p_overflow_flag;
    @(posedge clk_i) disable iff (reset_i) wrap16 |=> cf_reg ##1 (cf_reg || $past(wr_cs));
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("overflow flag not set or lost");

endmodule

// *** src/counter_array_regs.svh ***
`ifndef COUNTER_ARRAY_REGS_SVH
`define COUNTER_ARRAY_REGS_SVH
// Function
// - watchdog enabled coming out of every reset
// - service byte compares counter high byte
// - counter forced running while watchdog enabled
// - counter byte writes ignored while enabled
// - clock select and idle bit frozen
// - module 5 mode writes ignored while enabled
// - run bit writes cannot stop counter
// - run bit reads zero unless software set
// - service write loads high byte plus offset
// - low overflow at service match resets
// - writing 1 to module5 flag forces reset
// - timeout is 256*offset plus 256 minus low
// - enable bit or lock bit enables watchdog
// - lock refuses disable until system reset
// - unlocked clear of enable disables watchdog
// - reset defaults: divide by 12, zero bytes
// - overflow flag set on wrap, software clears
// - enabled overflow flag raises array interrupt
// - run bit stops or starts the counter
// - match flags set by hardware, software clears
// - 16-bit pwm: zero is full, no enable zero
// - clock select picks counter timebase
// - idle suspend pauses array in idle
// - enable bit set blocks other mode bits except lock
// - overflow interrupt enable gates overflow flag

// register addresses
`define ADDR_CONTROL_STATUS 8'hd8
`define ADDR_MODE           8'hd9
`define ADDR_COUNT_LOW      8'he1
`define ADDR_COUNT_HIGH     8'he2
`define ADDR_WD_OFFSET      8'he3
`define ADDR_WD_SERVICE     8'he4
`define ADDR_MODULE5_MODE   8'he5

// control status fields
`define CS_OVERFLOW_BIT 7
`define CS_RUN_BIT      6
`define CS_MATCH5_BIT   5

// mode register fields
`define MD_IDLE_BIT     7
`define MD_ENABLE_BIT   6
`define MD_LOCK_BIT     5
`define MD_CPS_LSB      1
`define MD_ECF_BIT      0

// module 5 mode register fields
`define M5_PWM16_BIT    7
`define M5_ECOM_BIT     6
`define M5_MAT_BIT      3
`define M5_PWM_BIT      1
`define M5_ECCF_BIT     0

// reset values
`define RESET_CONTROL_STATUS 8'h00
`define RESET_MODE           8'h40
`define RESET_COUNT          16'h0000
`define RESET_BYTE           8'h00

// clock source codes and divisors
`define CPS_DIV12  3'h0
`define CPS_DIV4   3'h1
`define CPS_TIMER0 3'h2
`define CPS_ECI    3'h3
`define CPS_SYSTEM_CLOCK 3'h4
`define CPS_EXT8   3'h5
`define CPS_RTC8   3'h6
`define DIV12_LAST 4'hb
`define DIV4_LAST  2'h3
`endif

// *** src/counter_array_pkg.sv ***
package counter_array_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_req_type;
endpackage

// *** testbench/system_model.sv ***
`include "counter_array_regs.svh"
module system_model
  import counter_array_pkg::*;
(
  // clock and register access
  input  wire logic       clk_i,
  output sfr_req_type     sfr_req_o,
  input  wire logic [7:0] sfr_rdata_i,
  // reset request handling
  input  wire logic       wd_reset_i,
  output logic            sys_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_wd_reset = 0;
  int hold       = 0;

  initial sfr_req_o = '0;

  // a reset request holds the system in reset for four clocks
  always @(posedge clk_i)
  begin
    if (wd_reset_i === 1'b1)
    begin
      n_wd_reset <= n_wd_reset + 1;
      hold       <= 4;
    end
    else if (hold != 0)
      hold <= hold - 1;
  end
  assign sys_reset_o = (hold != 0);

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    #1;
    sfr_req_o <= '{1'b1, 1'b0, addr, data};
    @(posedge clk_i);
    #1;
    sfr_req_o <= '0;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_i);
    #1;
    sfr_req_o <= '{1'b0, 1'b1, addr, 8'h00};
    @(posedge clk_i);
    #1;
    sfr_req_o <= '0;
    @(posedge clk_i);
    #1;
    data = sfr_rdata_i;
  endtask

  // disable, pick timebase, load offset, enable, then service
  task automatic configure(input logic [7:0] mode, input logic [7:0] offset);
    write_reg(`ADDR_MODE, 8'h00);
    write_reg(`ADDR_MODE, mode & 8'hbf);
    write_reg(`ADDR_WD_OFFSET, offset);
    write_reg(`ADDR_MODE, mode);
    write_reg(`ADDR_WD_SERVICE, 8'h00);
  endtask
endmodule

// *** testbench/counter_array_watchdog_tb.sv ***
`include "counter_array_regs.svh"
`define check_eq(name, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("Error %s expected %h seen %h", name, exp, got); \
    end \
  end

module counter_array_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           clk_i     = 1'b0;
  logic                           por_reset = 1'b1;
  logic                           sys_reset;
  counter_array_pkg::sfr_req_type sfr_req;
  logic [7:0]                     rdata;
  logic [4:0]                     match     = '0;
  logic [4:0]                     irq_en    = '0;
  logic                           wd_reset;
  logic                           irq;
  logic                           idle      = 1'b0;
  logic                           pwm5;
  int                             n_mismatch = 0;
  int                             n_compared = 0;
  logic [7:0]                     val;
  logic [7:0]                     val2;
  int                             cycles;
  int                             n_before;

  always #5 clk_i = ~clk_i;

  counter_array_watchdog uut (
    .clk_i           (clk_i),
    .reset_i         (por_reset | sys_reset),
    .sfr_req_i       (sfr_req),
    .sfr_rdata_o     (rdata),
    .idle_i          (idle),
    .timer0_ovf_i    (1'b0),
    .eci_pin_i       (1'b0),
    .ext_div8_tick_i (1'b0),
    .rtc_div8_tick_i (1'b0),
    .module_match_i  (match),
    .module_irq_en_i (irq_en),
    .wd_reset_o      (wd_reset),
    .irq_o           (irq),
    .pwm5_o          (pwm5)
  );

  system_model core (
    .clk_i       (clk_i),
    .sfr_req_o   (sfr_req),
    .sfr_rdata_i (rdata),
    .wd_reset_i  (wd_reset),
    .sys_reset_o (sys_reset)
  );

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // counts clocks until a reset request, then lets the system reset pass
  task automatic wait_wd(input int limit, output int count);
    count = 0;
    while (wd_reset !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      count++;
      if (count > limit)
      begin
        n_mismatch++;
        stop_test();
      end
    end
    repeat (8) @(posedge clk_i);
  endtask

  task automatic t_default();
    wait_wd(3200, cycles);
    `check_eq("first timeout", 1'b1, cycles >= 3070 && cycles <= 3090)
    core.read_reg(`ADDR_MODE, val);
    `check_eq("mode after reset", 8'h40, val)
    core.read_reg(`ADDR_CONTROL_STATUS, val);
    `check_eq("run bit", 8'h00, val)
    core.write_reg(`ADDR_COUNT_HIGH, 8'h55);
    core.read_reg(`ADDR_COUNT_HIGH, val);
    `check_eq("count high write", 8'h00, val)
    core.write_reg(`ADDR_MODE, 8'hce);
    core.read_reg(`ADDR_MODE, val);
    `check_eq("mode frozen", 8'h40, val)
    core.write_reg(`ADDR_MODULE5_MODE, 8'hc2);
    core.read_reg(`ADDR_MODULE5_MODE, val);
    `check_eq("module5 mode", 8'h00, val)
    core.read_reg(`ADDR_COUNT_LOW, val);
    repeat (30) @(posedge clk_i);
    core.read_reg(`ADDR_COUNT_LOW, val2);
    `check_eq("forced count", 1'b1, val2 != val)
  endtask

  task automatic t_service();
    core.write_reg(`ADDR_MODE, 8'h00);
    core.write_reg(`ADDR_COUNT_HIGH, 8'h10);
    core.write_reg(`ADDR_COUNT_LOW, 8'h00);
    core.read_reg(`ADDR_COUNT_HIGH, val);
    `check_eq("count high unlocked", 8'h10, val)
    core.configure(8'h48, 8'h02);
    core.read_reg(`ADDR_WD_SERVICE, val);
    `check_eq("service load", 8'h12, val)
    wait_wd(800, cycles);
    `check_eq("service timeout", 1'b1, cycles >= 755 && cycles <= 775)
  endtask

  task automatic t_lock();
    core.write_reg(`ADDR_MODE, 8'h00);
    core.write_reg(`ADDR_MODE, 8'h20);
    core.write_reg(`ADDR_MODE, 8'h00);
    core.read_reg(`ADDR_MODE, val);
    `check_eq("lock holds", 8'h20, val)
    core.write_reg(`ADDR_COUNT_HIGH, 8'h33);
    core.read_reg(`ADDR_COUNT_HIGH, val);
    `check_eq("lock enables", 8'h00, val)
    n_before = core.n_wd_reset;
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h20);
    wait_wd(4, cycles);
    `check_eq("forced reset", 32'd1, core.n_wd_reset - n_before)
    core.read_reg(`ADDR_MODE, val);
    `check_eq("lock cleared", 8'h40, val)
  endtask

  task automatic t_overflow();
    core.write_reg(`ADDR_MODE, 8'h00);
    core.write_reg(`ADDR_COUNT_HIGH, 8'hff);
    core.write_reg(`ADDR_COUNT_LOW, 8'hf0);
    core.write_reg(`ADDR_MODE, 8'h08);
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h40);
    repeat (30) @(posedge clk_i);
    core.read_reg(`ADDR_CONTROL_STATUS, val);
    `check_eq("overflow flag", 8'hc0, val)
    `check_eq("masked irq", 1'b0, irq)
    core.write_reg(`ADDR_MODE, 8'h09);
    repeat (3) @(posedge clk_i);
    #1;
    `check_eq("overflow irq", 1'b1, irq)
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h40);
    @(posedge clk_i);
    #1;
    match = 5'h01;
    @(posedge clk_i);
    #1;
    match = 5'h00;
    irq_en = 5'h01;
    core.read_reg(`ADDR_CONTROL_STATUS, val);
    `check_eq("match flag", 8'h41, val)
    `check_eq("match irq", 1'b1, irq)
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h00);
    core.read_reg(`ADDR_COUNT_LOW, val);
    repeat (5) @(posedge clk_i);
    core.read_reg(`ADDR_COUNT_LOW, val2);
    `check_eq("stopped count", val, val2)
    core.read_reg(`ADDR_CONTROL_STATUS, val);
    `check_eq("flags cleared", 8'h00, val)
  endtask

  // two low-byte reads lie 40 clocks apart: ten ticks at divide by 4
  task automatic t_idle();
    core.write_reg(`ADDR_MODE, 8'h82);
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h40);
    idle = 1'b1;
    core.read_reg(`ADDR_COUNT_LOW, val);
    repeat (37) @(posedge clk_i);
    core.read_reg(`ADDR_COUNT_LOW, val2);
    `check_eq("idle count", val, val2)
    idle = 1'b0;
    core.read_reg(`ADDR_COUNT_LOW, val);
    repeat (37) @(posedge clk_i);
    core.read_reg(`ADDR_COUNT_LOW, val2);
    `check_eq("div4 count", 8'h0a, 8'(val2 - val))
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h00);
  endtask

  // compare value zero on module 5, counter wraps from 0xfff0
  task automatic t_pwm();
    core.write_reg(`ADDR_MODE, 8'h08);
    core.write_reg(`ADDR_COUNT_HIGH, 8'hff);
    core.write_reg(`ADDR_COUNT_LOW, 8'hf0);
    core.write_reg(`ADDR_MODULE5_MODE, 8'hcb);
    core.write_reg(`ADDR_WD_OFFSET, 8'h00);
    core.write_reg(`ADDR_WD_SERVICE, 8'h00);
    `check_eq("pwm before match", 1'b0, pwm5)
    core.read_reg(`ADDR_MODULE5_MODE, val);
    `check_eq("module5 mode written", 8'hcb, val)
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h40);
    repeat (30) @(posedge clk_i);
    #1;
    `check_eq("pwm full duty", 1'b1, pwm5)
    `check_eq("module5 irq", 1'b1, irq)
    core.read_reg(`ADDR_CONTROL_STATUS, val);
    `check_eq("module5 flag", 8'he0, val)
    core.write_reg(`ADDR_WD_OFFSET, 8'h00);
    @(posedge clk_i);
    #1;
    `check_eq("pwm zero duty", 1'b0, pwm5)
    core.write_reg(`ADDR_CONTROL_STATUS, 8'h00);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    por_reset = 1'b0;
    t_default();
    t_service();
    t_lock();
    t_overflow();
    t_idle();
    t_pwm();
    stop_test();
  end
endmodule
